/* afs_pkg.sv */
package afs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_REMOTE1_SLOPE_CFG = 8'h5f;
  localparam logic [7:0] IDX_LOCAL_SLOPE_CFG = 8'h60;
  localparam logic [7:0] IDX_REMOTE2_SLOPE_CFG = 8'h61;
  localparam logic [7:0] IDX_ACOUSTIC_CFG_ONE = 8'h62;
  localparam logic [7:0] IDX_ACOUSTIC_CFG_TWO = 8'h63;
  localparam logic [7:0] IDX_REMOTE1_CRITICAL_LIMIT = 8'h6a;
  localparam logic [7:0] IDX_LOCAL_CRITICAL_LIMIT = 8'h6b;
  localparam logic [7:0] IDX_REMOTE2_CRITICAL_LIMIT = 8'h6c;
  localparam logic [7:0] IDX_REMOTE1_LOCAL_HYSTERESIS = 8'h6d;
  localparam logic [7:0] IDX_REMOTE2_HYSTERESIS = 8'h6e;
  localparam logic [7:0] IDX_FAN_STATUS = 8'h70;
  localparam logic [7:0] IDX_DUTY_OUT1 = 8'h71;
  localparam logic [7:0] IDX_DUTY_OUT2 = 8'h72;
  localparam logic [7:0] IDX_DUTY_OUT3 = 8'h73;
  localparam logic [7:0] IDX_OUT_CHANNEL_SEL = 8'h74;

  // Reset values.
  localparam logic [7:0] RST_SLOPE_CFG = 8'hc0;
  localparam logic [7:0] RST_ACOUSTIC_CFG = 8'h00;
  localparam logic [7:0] RST_CRITICAL_LIMIT = 8'h64;
  localparam logic [7:0] RST_REMOTE1_LOCAL_HYST = 8'h44;
  localparam logic [7:0] RST_REMOTE2_HYST = 8'h40;
  localparam logic [7:0] RST_OUT_CHANNEL_SEL = 8'h24;

  // Field positions.
  localparam int SLOPE_SPAN_LSB = 4;
  localparam int HYST_HI_LSB = 4;
  localparam int HYST_LO_LSB = 0;
  localparam int KEEP_SPIN_OUT1_BIT = 5;
  localparam int KEEP_SPIN_OUT2_BIT = 6;
  localparam int KEEP_SPIN_OUT3_BIT = 7;
  localparam int RAMP_STEP_OUT1_EN_OUT1_BIT = 3;
  localparam int RAMP_STEP_OUT1_EN_OUT2_BIT = 7;
  localparam int RAMP_STEP_OUT1_EN_OUT3_BIT = 3;
  localparam int RAMP_STEP_OUT1_LSB = 0;
  localparam int RAMP_STEP_OUT2_LSB = 4;
  localparam int RAMP_STEP_OUT3_LSB = 0;
  localparam int STATUS_CRIT_BIT = 0;
  localparam int STATUS_FAN_ON_LSB = 1;

  // Duty and temperature figures.
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] SLOTS_PER_PERIOD = 8'hff;
  localparam logic [8:0] CRITICAL_HYST_DEGC = 9'h004;

  // Timing.
  localparam int CLK_HZ = 25000000;
  localparam int SLOT_CLKS_DEFAULT = 4;

endpackage

/* afs_fan_ctrl.sv */
// Contract
// - Slope nibble selects control span, default 32 degC.
// - Slope registers map to remote1, local, remote2.
// - Any channel over critical limit forces full duty.
// - Full duty holds until below limit minus 4.
// - Critical override cannot be masked by settings.
// - Three critical limit registers, reset 100 degC.
// - Fan hysteresis programmable 1 to 15, default 4.
// - Register 0x6D holds remote1 and local hysteresis.
// - Register 0x6E upper nibble holds remote2 hysteresis.
// - Fan stays on until start minus hysteresis.
// - Bit 7 picks off or floor for out3.
// - Bit 6 picks off or floor for out2.
// - Bit 5 picks off or floor for out1.
// - Kept-spinning output ignores hysteresis when cooling.
// - Without acoustic mode duty follows temperature immediately.
// - Acoustic mode limits duty change per update.
// - Acoustic mode steps fixed amount toward target.
// - Acoustic mode selectable per output independently.
// - Acoustic enables at 0x62 bit3, 0x63 bits 7,3.
// - Ramp code selects 1,2,3,5,8,12,24,48 slots.
// - PWM period has 255 equal slots.
module afs_fan_ctrl
  import afs_pkg::*;
#(
  parameter int SLOT_CLKS = SLOT_CLKS_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic TEMP_UPDATE,
  input wire logic [7:0] TEMP_REMOTE1,
  input wire logic [7:0] TEMP_LOCAL,
  input wire logic [7:0] TEMP_REMOTE2,
  input wire logic [7:0] START_THRESH_REMOTE1,
  input wire logic [7:0] START_THRESH_LOCAL,
  input wire logic [7:0] START_THRESH_REMOTE2,
  input wire logic [7:0] FLOOR_DUTY_OUT1,
  input wire logic [7:0] FLOOR_DUTY_OUT2,
  input wire logic [7:0] FLOOR_DUTY_OUT3,
  output logic PWM_OUT1,
  output logic PWM_OUT2,
  output logic PWM_OUT3,
  output logic CRITICAL_OVERRIDE
);

  if (SLOT_CLKS < 1 || SLOT_CLKS > 65535) begin : g_bad_slot
    $error("SLOT_CLKS must lie between 1 and 65535");
  end

  // Duty slots gained per degree above start, scaled by 16 (2720 / span).
  function automatic logic [10:0] slope_gain(input logic [3:0] code);
    logic [10:0] g;
    g = 11'h000;
    unique case (code)
      4'h0: g = 11'h550;
      4'h1: g = 11'h440;
      4'h2: g = 11'h330;
      4'h3: g = 11'h2a8;
      4'h4: g = 11'h220;
      4'h5: g = 11'h198;
      4'h6: g = 11'h154;
      4'h7: g = 11'h110;
      4'h8: g = 11'h0cc;
      4'h9: g = 11'h0aa;
      4'ha: g = 11'h088;
      4'hb: g = 11'h066;
      4'hc: g = 11'h055;
      4'hd: g = 11'h044;
      4'he: g = 11'h033;
      4'hf: g = 11'h022;
    endcase
    return g;
  endfunction

  function automatic logic [7:0] ramp_slots(input logic [2:0] code);
    logic [7:0] s;
    s = 8'h01;
    unique case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h05;
      3'h4: s = 8'h08;
      3'h5: s = 8'h0c;
      3'h6: s = 8'h18;
      3'h7: s = 8'h30;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt,
                                             input logic [7:0] step);
    logic [7:0] r;
    r = tgt;
    if (tgt > cur && (tgt - cur) > step) begin
      r = cur + step;
    end else if (tgt < cur && (cur - tgt) > step) begin
      r = cur - step;
    end
    return r;
  endfunction

  logic [7:0] slope_cfg_reg [3];
  logic [7:0] crit_limit_reg [3];
  logic [7:0] acoustic_one_reg;
  logic [7:0] acoustic_two_reg;
  logic [7:0] hyst_r1_local_reg;
  logic [7:0] hyst_r2_reg;
  logic [7:0] chan_sel_reg;
  logic [7:0] duty_reg [3];
  logic [2:0] fan_on_reg;
  logic crit_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] slot_div_reg;
  logic slot_tick_reg;
  logic [7:0] slot_cnt_reg;
  logic [7:0] duty_latched_reg [3];
  logic [2:0] pwm_reg;

  logic [7:0] temp [3];
  logic [7:0] start_th [3];
  logic [7:0] floor_duty [3];
  logic [3:0] hyst [3];
  logic [2:0] keep_spin;
  logic [2:0] ramp_step_out1_en;
  logic [2:0] ramp_code [3];
  logic [7:0] target [3];
  logic [2:0] fan_on_next;
  logic crit_next;
  logic [7:0] adr_idx;
  logic wb_req;
  logic [7:0] rd_byte;

  assign temp[0] = TEMP_REMOTE1;
  assign temp[1] = TEMP_LOCAL;
  assign temp[2] = TEMP_REMOTE2;
  assign start_th[0] = START_THRESH_REMOTE1;
  assign start_th[1] = START_THRESH_LOCAL;
  assign start_th[2] = START_THRESH_REMOTE2;
  assign floor_duty[0] = FLOOR_DUTY_OUT1;
  assign floor_duty[1] = FLOOR_DUTY_OUT2;
  assign floor_duty[2] = FLOOR_DUTY_OUT3;
  assign hyst[0] = hyst_r1_local_reg[HYST_HI_LSB +: 4];
  assign hyst[1] = hyst_r1_local_reg[HYST_LO_LSB +: 4];
  assign hyst[2] = hyst_r2_reg[HYST_HI_LSB +: 4];
  assign keep_spin[0] = acoustic_one_reg[KEEP_SPIN_OUT1_BIT];
  assign keep_spin[1] = acoustic_one_reg[KEEP_SPIN_OUT2_BIT];
  assign keep_spin[2] = acoustic_one_reg[KEEP_SPIN_OUT3_BIT];
  assign ramp_step_out1_en[0] = acoustic_one_reg[RAMP_STEP_OUT1_EN_OUT1_BIT];
  assign ramp_step_out1_en[1] = acoustic_two_reg[RAMP_STEP_OUT1_EN_OUT2_BIT];
  assign ramp_step_out1_en[2] = acoustic_two_reg[RAMP_STEP_OUT1_EN_OUT3_BIT];
  assign ramp_code[0] = acoustic_one_reg[RAMP_STEP_OUT1_LSB +: 3];
  assign ramp_code[1] = acoustic_two_reg[RAMP_STEP_OUT2_LSB +: 3];
  assign ramp_code[2] = acoustic_two_reg[RAMP_STEP_OUT3_LSB +: 3];

  assign adr_idx = WB_ADR_I[9:2];
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;

  // Hysteresis state per channel: on above start, off only below start minus hysteresis.
  always_comb begin
    fan_on_next = fan_on_reg;
    for (int c = 0; c < 3; c++) begin
      if (temp[c] > start_th[c]) begin
        fan_on_next[c] = 1'b1;
      end else if ({1'b0, temp[c]} + {5'h00, hyst[c]} < {1'b0, start_th[c]}) begin
        fan_on_next[c] = 1'b0;
      end
    end
  end

  // The override leaves only when every channel has cooled past its release point.
  always_comb begin
    crit_next = crit_reg;
    for (int c = 0; c < 3; c++) begin
      if (temp[c] > crit_limit_reg[c]) begin
        crit_next = 1'b1;
      end
    end
    if (crit_reg && ({1'b0, temp[0]} + CRITICAL_HYST_DEGC < {1'b0, crit_limit_reg[0]})
        && ({1'b0, temp[1]} + CRITICAL_HYST_DEGC < {1'b0, crit_limit_reg[1]})
        && ({1'b0, temp[2]} + CRITICAL_HYST_DEGC < {1'b0, crit_limit_reg[2]})) begin
      crit_next = 1'b0;
    end
  end

  // Target duty per output from its selected channel.
  always_comb begin
    logic [1:0] ch;
    logic [7:0] diff;
    logic [18:0] prod;
    logic [15:0] sum;
    ch = 2'h0;
    diff = 8'h00;
    prod = 19'h00000;
    sum = 16'h0000;
    for (int o = 0; o < 3; o++) begin
      ch = chan_sel_reg[2*o +: 2];
      if (ch == 2'h3) begin
        ch = 2'h2;
      end
      diff = (temp[ch] > start_th[ch]) ? temp[ch] - start_th[ch] : 8'h00;
      prod = diff * slope_gain(slope_cfg_reg[ch][SLOPE_SPAN_LSB +: 4]);
      sum = {8'h00, floor_duty[o]} + {1'b0, prod[18:4]};
      if (fan_on_next[ch]) begin
        target[o] = (sum > 16'h00ff) ? DUTY_FULL : sum[7:0];
      end else begin
        // Kept-spinning outputs never see the off state, so hysteresis has no say.
        target[o] = keep_spin[o] ? floor_duty[o] : 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      fan_on_reg <= 3'h0;
      crit_reg <= 1'b0;
    end else if (TEMP_UPDATE) begin
      fan_on_reg <= fan_on_next;
      crit_reg <= crit_next;
    end
  end

  // Duty update on each new temperature set.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int o = 0; o < 3; o++) begin
        duty_reg[o] <= 8'h00;
      end
    end else if (TEMP_UPDATE) begin
      for (int o = 0; o < 3; o++) begin
        if (crit_next) begin
          duty_reg[o] <= DUTY_FULL;
        end else if (ramp_step_out1_en[o]) begin
          duty_reg[o] <= step_toward(duty_reg[o], target[o], ramp_slots(ramp_code[o]));
        end else begin
          duty_reg[o] <= target[o];
        end
      end
    end
  end

  // Slot divider and 255-slot period counter.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      slot_div_reg <= 16'h0000;
      slot_tick_reg <= 1'b0;
    end else if (slot_div_reg == 16'(SLOT_CLKS - 1)) begin
      slot_div_reg <= 16'h0000;
      slot_tick_reg <= 1'b1;
    end else begin
      slot_div_reg <= slot_div_reg + 16'h0001;
      slot_tick_reg <= 1'b0;
    end
  end

  // Duty is sampled only at the period start so a mid-period update cannot glitch a pulse.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      slot_cnt_reg <= 8'h00;
      for (int o = 0; o < 3; o++) begin
        duty_latched_reg[o] <= 8'h00;
      end
    end else if (slot_tick_reg) begin
      if (slot_cnt_reg == SLOTS_PER_PERIOD - 8'h01) begin
        slot_cnt_reg <= 8'h00;
        for (int o = 0; o < 3; o++) begin
          duty_latched_reg[o] <= duty_reg[o];
        end
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pwm_reg <= 3'h0;
    end else begin
      for (int o = 0; o < 3; o++) begin
        pwm_reg[o] <= slot_cnt_reg < duty_latched_reg[o];
      end
    end
  end

  assign PWM_OUT1 = pwm_reg[0];
  assign PWM_OUT2 = pwm_reg[1];
  assign PWM_OUT3 = pwm_reg[2];
  assign CRITICAL_OVERRIDE = crit_reg;

  // Register writes take effect at the edge that raises ack.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int c = 0; c < 3; c++) begin
        slope_cfg_reg[c] <= RST_SLOPE_CFG;
        crit_limit_reg[c] <= RST_CRITICAL_LIMIT;
      end
      acoustic_one_reg <= RST_ACOUSTIC_CFG;
      acoustic_two_reg <= RST_ACOUSTIC_CFG;
      hyst_r1_local_reg <= RST_REMOTE1_LOCAL_HYST;
      hyst_r2_reg <= RST_REMOTE2_HYST;
      chan_sel_reg <= RST_OUT_CHANNEL_SEL;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
      unique case (adr_idx)
        IDX_REMOTE1_SLOPE_CFG: slope_cfg_reg[0] <= WB_DAT_I[7:0];
        IDX_LOCAL_SLOPE_CFG: slope_cfg_reg[1] <= WB_DAT_I[7:0];
        IDX_REMOTE2_SLOPE_CFG: slope_cfg_reg[2] <= WB_DAT_I[7:0];
        IDX_ACOUSTIC_CFG_ONE: acoustic_one_reg <= WB_DAT_I[7:0];
        IDX_ACOUSTIC_CFG_TWO: acoustic_two_reg <= WB_DAT_I[7:0];
        IDX_REMOTE1_CRITICAL_LIMIT: crit_limit_reg[0] <= WB_DAT_I[7:0];
        IDX_LOCAL_CRITICAL_LIMIT: crit_limit_reg[1] <= WB_DAT_I[7:0];
        IDX_REMOTE2_CRITICAL_LIMIT: crit_limit_reg[2] <= WB_DAT_I[7:0];
        IDX_REMOTE1_LOCAL_HYSTERESIS: hyst_r1_local_reg <= WB_DAT_I[7:0];
        IDX_REMOTE2_HYSTERESIS: hyst_r2_reg <= {WB_DAT_I[7:4], 4'h0};
        IDX_OUT_CHANNEL_SEL: chan_sel_reg <= {2'h0, WB_DAT_I[5:0]};
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (adr_idx)
      IDX_REMOTE1_SLOPE_CFG: rd_byte = slope_cfg_reg[0];
      IDX_LOCAL_SLOPE_CFG: rd_byte = slope_cfg_reg[1];
      IDX_REMOTE2_SLOPE_CFG: rd_byte = slope_cfg_reg[2];
      IDX_ACOUSTIC_CFG_ONE: rd_byte = acoustic_one_reg;
      IDX_ACOUSTIC_CFG_TWO: rd_byte = acoustic_two_reg;
      IDX_REMOTE1_CRITICAL_LIMIT: rd_byte = crit_limit_reg[0];
      IDX_LOCAL_CRITICAL_LIMIT: rd_byte = crit_limit_reg[1];
      IDX_REMOTE2_CRITICAL_LIMIT: rd_byte = crit_limit_reg[2];
      IDX_REMOTE1_LOCAL_HYSTERESIS: rd_byte = hyst_r1_local_reg;
      IDX_REMOTE2_HYSTERESIS: rd_byte = hyst_r2_reg;
      IDX_FAN_STATUS: begin
        rd_byte[STATUS_CRIT_BIT] = crit_reg;
        rd_byte[STATUS_FAN_ON_LSB +: 3] = fan_on_reg;
      end
      IDX_DUTY_OUT1: rd_byte = duty_reg[0];
      IDX_DUTY_OUT2: rd_byte = duty_reg[1];
      IDX_DUTY_OUT3: rd_byte = duty_reg[2];
      IDX_OUT_CHANNEL_SEL: rd_byte = chan_sel_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: ack rises the edge after the request and falls the next.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !WB_WE_I) begin
        rdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

endmodule

/* afs_fan_ctrl_sva.sv */
module afs_fan_ctrl_sva
  import afs_pkg::*;
#(
  parameter int SLOT_CLKS = SLOT_CLKS_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic TEMP_UPDATE,
  input wire logic PWM_OUT1,
  input wire logic PWM_OUT2,
  input wire logic PWM_OUT3,
  input wire logic CRITICAL_OVERRIDE
);
  // Full duty is latched only at a period start, so two whole periods are allowed.
  localparam int LIM = 2 * 255 * SLOT_CLKS + 4;
  int crit_cnt;
  logic seen_upd;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  always_ff @(posedge CLK) begin
    if (!RST_B || !CRITICAL_OVERRIDE) begin
      crit_cnt <= 0;
    end else if (crit_cnt < LIM) begin
      crit_cnt <= crit_cnt + 1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      seen_upd <= 1'b0;
    end else if (TEMP_UPDATE) begin
      seen_upd <= 1'b1;
    end
  end
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  AST_ACK_ANSWER: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  AST_DAT_UPPER: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_CRIT_ON_UPDATE: assert property ($changed(CRITICAL_OVERRIDE) |-> $past(TEMP_UPDATE))
    else $error("override moved without update");
  AST_CRIT_FULL: assert property (crit_cnt == LIM && CRITICAL_OVERRIDE |->
    PWM_OUT1 && PWM_OUT2 && PWM_OUT3) else $error("override without full duty");
  AST_RESET_IDLE: assert property ($rose(RST_B) |->
    !CRITICAL_OVERRIDE && !PWM_OUT1 && !PWM_OUT2 && !PWM_OUT3) else $error("busy after reset");
  AST_OFF_BEFORE_UPDATE: assert property (!seen_upd |->
    !PWM_OUT1 && !PWM_OUT2 && !PWM_OUT3) else $error("drive before update");
endmodule

bind afs_fan_ctrl afs_fan_ctrl_sva #(.SLOT_CLKS(SLOT_CLKS)) i_sva (.CLK(CLK), .RST_B(RST_B),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .TEMP_UPDATE(TEMP_UPDATE), .PWM_OUT1(PWM_OUT1), .PWM_OUT2(PWM_OUT2), .PWM_OUT3(PWM_OUT3),
  .CRITICAL_OVERRIDE(CRITICAL_OVERRIDE));

/* afs_fan_model.sv */
module afs_fan_model #(
  parameter int SLOT_CLKS = 1
) (
  input wire logic clk,
  input wire logic pwm,
  output logic [7:0] duty_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // A fan sees only its drive line, so duty is high time over one whole period.
  int cyc_cnt = 0;
  int high_cnt = 0;
  initial duty_seen = 8'h00;
  always @(posedge clk) begin
    if (cyc_cnt == 255 * SLOT_CLKS - 1) begin
      duty_seen <= 8'((high_cnt + pwm) / SLOT_CLKS);
      cyc_cnt <= 0;
      high_cnt <= 0;
    end else begin
      cyc_cnt <= cyc_cnt + 1;
      high_cnt <= high_cnt + pwm;
    end
  end
endmodule

/* test_auto_fan_slope_limit_ctrl.sv */
module test_auto_fan_slope_limit_ctrl
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, upd = 1'b0;
  logic ack, o1, o2, o3, crit;
  logic [11:0] adr = 12'h000;
  logic [31:0] dati = 32'h00000000;
  logic [31:0] dato;
  logic [3:0] sel = 4'h1;
  logic [7:0] t1 = 8'h1e, tl = 8'h1e, t2 = 8'h1e, sth = 8'h28, flr = 8'h0a;
  logic [7:0] rd, seen1, seen2, seen3;
  int mismatches = 0;
  int checked = 0;
  always #20 clk = ~clk;
  afs_fan_ctrl #(.SLOT_CLKS(1)) i_dut (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dati), .WB_SEL_I(sel), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .TEMP_UPDATE(upd), .TEMP_REMOTE1(t1), .TEMP_LOCAL(tl), .TEMP_REMOTE2(t2),
    .START_THRESH_REMOTE1(sth), .START_THRESH_LOCAL(sth), .START_THRESH_REMOTE2(sth),
    .FLOOR_DUTY_OUT1(flr), .FLOOR_DUTY_OUT2(flr), .FLOOR_DUTY_OUT3(flr), .PWM_OUT1(o1),
    .PWM_OUT2(o2), .PWM_OUT3(o3), .CRITICAL_OVERRIDE(crit));
  afs_fan_model #(.SLOT_CLKS(1)) i_fan (.clk(clk), .pwm(o1), .duty_seen(seen1));
  afs_fan_model #(.SLOT_CLKS(1)) i_fan2 (.clk(clk), .pwm(o2), .duty_seen(seen2));
  afs_fan_model #(.SLOT_CLKS(1)) i_fan3 (.clk(clk), .pwm(o3), .duty_seen(seen3));
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    dati <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      chk("ack", 8'h01, 8'h00);
      end_sim();
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic tu(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk);
    t1 <= a;
    tl <= b;
    t2 <= c;
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask
  task automatic tch(input int ch, input logic [7:0] v);
    tu(ch == 0 ? v : 8'h1e, ch == 1 ? v : 8'h1e, ch == 2 ? v : 8'h1e);
    @(negedge clk);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic t_regs;
    logic [7:0] ix [10] = '{8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e};
    logic [7:0] rv [10] = '{8'hc0, 8'hc0, 8'hc0, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40};
    for (int i = 0; i < 10; i++) rdchk("reset value", ix[i], rv[i]);
    wb(1'b1, 8'h50, 8'ha5);
    rdchk("unmapped", 8'h50, 8'h00);
    wb(1'b1, IDX_REMOTE2_CRITICAL_LIMIT, 8'h5a);
    rdchk("limit", IDX_REMOTE2_CRITICAL_LIMIT, 8'h5a);
    wb(1'b1, IDX_REMOTE2_CRITICAL_LIMIT, RST_CRITICAL_LIMIT);
    $display("t_regs done");
  endtask
  task automatic t_slope;
    logic [3:0] cd [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'hd, 4'hf};
    logic [7:0] dt [11] = '{8'h02, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h10, 8'h14, 8'h20,
      8'h28, 8'h50};
    sth <= 8'h0a;
    for (int i = 0; i < 11; i++) begin
      wb(1'b1, IDX_REMOTE1_SLOPE_CFG, {cd[i], 4'h0});
      tu(8'h0a + dt[i], 8'h05, 8'h05);
      rdchk("slope duty", IDX_DUTY_OUT1, (i == 1) ? 8'h92 : 8'hb4);
    end
    wb(1'b1, IDX_LOCAL_SLOPE_CFG, 8'hd0);
    wb(1'b1, IDX_REMOTE2_SLOPE_CFG, 8'hf0);
    tu(8'h5a, 8'h32, 8'h5a);
    rdchk("local slope", IDX_DUTY_OUT2, 8'hb4);
    rdchk("remote2 slope", IDX_DUTY_OUT3, 8'hb4);
    // A new duty reaches the pins only at a period start, so the fans' window must begin later.
    repeat (800) @(posedge clk);
    chk("fan duty", 8'hb4, seen1);
    chk("fan2 duty", 8'hb4, seen2);
    chk("fan3 duty", 8'hb4, seen3);
    wb(1'b1, IDX_REMOTE1_SLOPE_CFG, RST_SLOPE_CFG);
    wb(1'b1, IDX_LOCAL_SLOPE_CFG, RST_SLOPE_CFG);
    wb(1'b1, IDX_REMOTE2_SLOPE_CFG, RST_SLOPE_CFG);
    $display("t_slope done");
  endtask
  task automatic t_crit;
    sth <= 8'h28;
    wb(1'b1, IDX_ACOUSTIC_CFG_ONE, 8'h08);
    for (int ch = 0; ch < 3; ch++) begin
      tch(ch, 8'h65);
      chk("override", 8'h01, {7'h00, crit});
      for (int o = 0; o < 3; o++) rdchk("full", IDX_DUTY_OUT1 + 8'(o), DUTY_FULL);
      if (ch == 0) begin
        repeat (800) @(posedge clk);
        chk("fan full", DUTY_FULL, seen1);
        chk("fan2 full", DUTY_FULL, seen2);
        chk("fan3 full", DUTY_FULL, seen3);
      end
      tch(ch, 8'h60);
      chk("override held", 8'h01, {7'h00, crit});
      tch(ch, 8'h5f);
      chk("override left", 8'h00, {7'h00, crit});
    end
    rdchk("status", IDX_FAN_STATUS, 8'h08);
    for (int ch = 0; ch < 3; ch++) begin
      wb(1'b1, IDX_REMOTE1_CRITICAL_LIMIT + 8'(ch), 8'h50);
      tch(ch, 8'h51);
      chk("limit map", 8'h01, {7'h00, crit});
      wb(1'b1, IDX_REMOTE1_CRITICAL_LIMIT + 8'(ch), RST_CRITICAL_LIMIT);
      tch(ch, 8'h1e);
      chk("limit map left", 8'h00, {7'h00, crit});
    end
    wb(1'b1, IDX_ACOUSTIC_CFG_ONE, 8'h00);
    $display("t_crit done");
  endtask
  task automatic t_hyst;
    logic [2:0] ks [2] = '{3'h3, 3'h6};
    flr <= 8'h14;
    wb(1'b1, IDX_REMOTE1_LOCAL_HYSTERESIS, 8'h34);
    tu(8'h29, 8'h1e, 8'h1e);
    rdchk("fan on", IDX_FAN_STATUS, 8'h02);
    tu(8'h25, 8'h1e, 8'h1e);
    rdchk("fan held", IDX_FAN_STATUS, 8'h02);
    tu(8'h24, 8'h1e, 8'h1e);
    rdchk("fan off", IDX_FAN_STATUS, 8'h00);
    for (int o = 0; o < 3; o++) rdchk("off", IDX_DUTY_OUT1 + 8'(o), 8'h00);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, IDX_ACOUSTIC_CFG_ONE, {ks[k], 5'h00});
      tu(8'h24, 8'h1e, 8'h1e);
      for (int o = 0; o < 3; o++) begin
        rdchk("floor", IDX_DUTY_OUT1 + 8'(o), ks[k][o] ? 8'h14 : 8'h00);
      end
    end
    wb(1'b1, IDX_ACOUSTIC_CFG_ONE, 8'h00);
    $display("t_hyst done");
  endtask
  task automatic t_ramp_step_out1;
    logic [7:0] st [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
    flr <= 8'h0a;
    wb(1'b1, IDX_OUT_CHANNEL_SEL, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, IDX_ACOUSTIC_CFG_ONE, 8'h00);
      wb(1'b1, IDX_ACOUSTIC_CFG_TWO, 8'h00);
      tu(8'h1e, 8'h1e, 8'h1e);
      wb(1'b1, IDX_ACOUSTIC_CFG_ONE, 8'h08 | 8'(c));
      wb(1'b1, IDX_ACOUSTIC_CFG_TWO, 8'h08 | 8'(c));
      tu(8'h48, 8'h1e, 8'h1e);
      rdchk("ramp out1", IDX_DUTY_OUT1, st[c]);
      rdchk("ramp out3", IDX_DUTY_OUT3, st[c]);
      rdchk("plain out2", IDX_DUTY_OUT2, 8'hb4);
      tu(8'h48, 8'h1e, 8'h1e);
      rdchk("ramp up", IDX_DUTY_OUT1, st[c] * 8'h02);
      tu(8'h1e, 8'h1e, 8'h1e);
      rdchk("ramp down", IDX_DUTY_OUT1, st[c]);
    end
    wb(1'b1, IDX_ACOUSTIC_CFG_TWO, 8'hf0);
    tu(8'h48, 8'h1e, 8'h1e);
    rdchk("ramp out2", IDX_DUTY_OUT2, 8'h30);
    $display("t_ramp_step_out1 done");
  endtask
  initial begin
    do_reset();
    t_regs();
    t_slope();
    t_crit();
    do_reset();
    t_hyst();
    t_ramp_step_out1();
    end_sim();
  end
endmodule
